//--- epd_defs.svh
// Constants of the execute-packet dispatch and timing block.
// Assumes it is included by bare name from the package and the module.
`ifndef EPD_DEFS_SVH
`define EPD_DEFS_SVH
`define EPD_WORDS 8
`define EPD_GROUP_BYTES 32'h0000_0020
`define EPD_PBIT 0
`define EPD_SIDE_BIT 1
`define EPD_UNIT_LSB 2
`define EPD_DIR_BIT 6
`define EPD_UNITSEL_BIT 7
`define EPD_CLS_LSB 8
`define EPD_XBIT 12
`define EPD_CTRL_OFS 8'h00
`define EPD_STAT_OFS 8'h04
`define EPD_CTRL_RST 2'h1
`define EPD_SP_BIAS 10'h07f
`define EPD_SP_DEN_EXP 10'h382
`define EPD_DP_BIAS 12'h3ff
`define EPD_DP_DEN_EXP 12'hc02
`define EPD_SP_EMAX 8'hff
`define EPD_DP_EMAX 11'h7ff
`define EPD_SP_NAN 32'h7fff_ffff
`define EPD_DP_NAN 64'h7fff_ffff_ffff_ffff
`define EPD_TM_SINGLE 16'h0120
`define EPD_TM_DP2 16'h1121
`define EPD_TM_DPCMP 16'h1242
`define EPD_TM_FOUR 16'h3126
`define EPD_TM_INT_TO_DP_CONVERT_OP 16'h4127
`define EPD_TM_LOAD 16'h4120
`define EPD_TM_SP2DP 16'h4227
`define EPD_TM_DP_ADD_OP 16'h624b
`define EPD_TM_SPDP 16'h634b
`define EPD_TM_INT32_MULTIPLY_OP 16'h8490
`define EPD_TM_INT32_MULTIPLY_WIDE_OP 16'h9491
`endif

//--- epd_pkg.sv
// Types of the execute-packet dispatch and timing block.
// Assumes epd_defs.svh is on the include path.
`include "epd_defs.svh"
package epd_pkg;
  typedef enum logic [3:0] {
    CLS_SINGLE = 4'h0, CLS_DP2 = 4'h1, CLS_DPCMP = 4'h2, CLS_FOUR = 4'h3,
    CLS_INT_TO_DP_CONVERT_OP = 4'h4, CLS_LOAD = 4'h5, CLS_SP2DP = 4'h6, CLS_DP_ADD_OP = 4'h7,
    CLS_DP_SUB_OP = 4'h8, CLS_SPDP = 4'h9, CLS_INT32_MULTIPLY_OP = 4'ha, CLS_INT32_MULTIPLY_WIDE_OP = 4'hb,
    CLS_DP_MULTIPLY_OP = 4'hc
  } epd_cls_t;
  typedef enum logic [2:0] {
    FP_ZERO = 3'h0, FP_NORMAL = 3'h1, FP_DENORMAL = 3'h2, FP_INF = 3'h3,
    FP_QNAN = 3'h4, FP_SNAN = 3'h5
  } epd_fp_t;
  typedef struct packed {
    logic [3:0] ds;
    logic [3:0] lat;
    logic [2:0] nrd;
    logic [3:0] wr;
    logic two;
  } epd_tm_t;
  typedef struct packed {
    logic [31:0] word;
    logic dst_b;
    logic src2_b;
    logic ldst_two;
    logic load;
  } epd_slot_t;
  typedef struct packed {
    logic [7:0][31:0] grp;
    logic have;
    logic [3:0] pos;
    logic [31:0] faddr;
    logic [7:0][31:0] pkt;
    logic [3:0] pcnt;
    logic iss;
    logic [7:0][$bits(epd_slot_t)-1:0] slot;
    logic [7:0] imask;
    logic conf;
    logic [7:0][3:0] ucnt;
    logic [7:0] uact;
    logic [7:0][15:0] utm;
    logic [2:0] spc;
    logic sps;
    logic [9:0] spe;
    logic [23:0] spm;
    logic [2:0] dpc;
    logic dps;
    logic [11:0] dpe;
    logic [52:0] dpm;
    logic [1:0] ctrl;
    logic awh;
    logic [7:0] awa;
    logic wh;
    logic [31:0] wd;
    logic bv;
    logic [1:0] br;
    logic rv;
    logic [31:0] rd;
    logic [1:0] rr;
  } epd_state_t;
endpackage : epd_pkg

//--- epd_dispatch.sv
// Execute-packet dispatcher with unit timing, operand classifier and
// an AXI4-Lite control port.
// Assumes fetch answers each aligned request with one eight-word group and
// that the units honour the strobes derived here.
//
// Design decisions made here: the AXI4-Lite slave port and the register addresses.
`include "epd_defs.svh"
module epd_dispatch #(
  parameter logic [31:0] START_ADDR = 32'h0000_0000
) (
  input wire logic aclk,
  input wire logic aresetn,
  output logic fetch_req,
  output logic [31:0] fetch_addr,
  input wire logic group_valid,
  input wire logic [255:0] group_data,
  output logic group_ready,
  output logic issue_valid,
  output logic [7:0] issue_mask,
  output logic [7:0][31:0] issue_word,
  output logic [7:0] issue_dst_b,
  output logic [7:0] issue_src2_b,
  output logic [7:0] issue_ldst_two,
  output logic [7:0] issue_load,
  output logic issue_unit_conflict,
  output logic [7:0] unit_busy,
  output logic [7:0] unit_read,
  output logic [7:0] unit_read_hi,
  output logic [7:0] unit_write_lo,
  output logic [7:0] unit_write_hi,
  output logic [7:0] unit_late_write,
  output logic [7:0] unit_readable,
  input wire logic [31:0] sp_operand,
  input wire logic [31:0] dp_even_word,
  input wire logic [31:0] dp_odd_word,
  output logic [2:0] sp_class,
  output logic sp_sign,
  output logic [9:0] sp_exponent,
  output logic [23:0] sp_mantissa,
  output logic [2:0] dp_class,
  output logic dp_sign,
  output logic [11:0] dp_exponent,
  output logic [52:0] dp_mantissa,
  output logic [31:0] default_quiet_nan_sp,
  output logic [63:0] default_quiet_nan_dp,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  epd_pkg::epd_state_t q;
  epd_pkg::epd_state_t d;
  logic [7:0] busy;

  function automatic logic [15:0] timing(input logic [3:0] c);
    case (c)
      epd_pkg::CLS_DP2: timing = `EPD_TM_DP2;
      epd_pkg::CLS_DPCMP: timing = `EPD_TM_DPCMP;
      epd_pkg::CLS_FOUR: timing = `EPD_TM_FOUR;
      epd_pkg::CLS_INT_TO_DP_CONVERT_OP: timing = `EPD_TM_INT_TO_DP_CONVERT_OP;
      epd_pkg::CLS_LOAD: timing = `EPD_TM_LOAD;
      epd_pkg::CLS_SP2DP: timing = `EPD_TM_SP2DP;
      epd_pkg::CLS_DP_ADD_OP: timing = `EPD_TM_DP_ADD_OP;
      epd_pkg::CLS_DP_SUB_OP: timing = `EPD_TM_DP_ADD_OP;
      epd_pkg::CLS_SPDP: timing = `EPD_TM_SPDP;
      epd_pkg::CLS_INT32_MULTIPLY_OP: timing = `EPD_TM_INT32_MULTIPLY_OP;
      epd_pkg::CLS_INT32_MULTIPLY_WIDE_OP: timing = `EPD_TM_INT32_MULTIPLY_WIDE_OP;
      epd_pkg::CLS_DP_MULTIPLY_OP: timing = `EPD_TM_INT32_MULTIPLY_WIDE_OP;
      default: timing = `EPD_TM_SINGLE;
    endcase
  endfunction : timing

  function automatic epd_pkg::epd_slot_t decode(input logic [31:0] w);
    decode.word = w;
    decode.dst_b = w[`EPD_SIDE_BIT];
    decode.src2_b = w[`EPD_SIDE_BIT] ^ w[`EPD_XBIT];
    decode.ldst_two = w[`EPD_UNITSEL_BIT];
    decode.load = w[`EPD_DIR_BIT];
  endfunction : decode

  // Operand decode is the same for both widths apart from field sizes.
  function automatic logic [2:0] fpcls(input logic emin, input logic emax,
      input logic fz, input logic fmsb);
    if (emin) begin
      fpcls = fz ? epd_pkg::FP_ZERO : epd_pkg::FP_DENORMAL;
    end else if (!emax) begin
      fpcls = epd_pkg::FP_NORMAL;
    end else if (fz) begin
      fpcls = epd_pkg::FP_INF;
    end else begin
      fpcls = fmsb ? epd_pkg::FP_QNAN : epd_pkg::FP_SNAN;
    end
  endfunction : fpcls

  genvar gu;
  generate
    for (gu = 0; gu < 8; gu++) begin : g_unit
      epd_pkg::epd_tm_t t;
      assign t = q.utm[gu];
      // Counts are relative to the issue cycle, which is the first stage.
      assign busy[gu] = q.uact[gu] && ({1'b0, q.ucnt[gu]} + 5'h01 <
        {1'b0, t.lat});
      assign unit_read[gu] = q.uact[gu] && ({1'b0, q.ucnt[gu]} <
        {2'h0, t.nrd});
      assign unit_read_hi[gu] = unit_read[gu] && t.nrd == 3'h2 &&
        q.ucnt[gu] == 4'h1;
      assign unit_write_lo[gu] = q.uact[gu] && q.ucnt[gu] == t.wr;
      assign unit_write_hi[gu] = q.uact[gu] && t.two &&
        q.ucnt[gu] == t.wr + 4'h1;
      assign unit_late_write[gu] = q.uact[gu] &&
        q.utm[gu] == `EPD_TM_LOAD && q.ucnt[gu] == t.ds;
      assign unit_readable[gu] = q.uact[gu] &&
        q.ucnt[gu] == t.ds + 4'h1;
    end
  endgenerate

  always_comb begin
    logic [7:0][31:0] ws;
    logic [3:0] n;
    logic open;
    logic closed;
    logic [3:0] npos;
    logic stall;
    logic [7:0] used;
    logic conf;
    logic [2:0] u;
    logic wr_ok;
    logic [7:0] ra;
    ws = q.pkt;
    n = q.pcnt;
    open = q.have;
    closed = 1'b0;
    npos = q.pos;
    stall = 1'b0;
    used = 8'h00;
    conf = 1'b0;
    u = 3'h0;
    wr_ok = 1'b0;
    ra = 8'h00;
    d = q;
    d.iss = 1'b0;
    d.conf = 1'b0;
    // Flags are walked in ascending word order before anything issues.
    for (int k = 0; k < 8; k++) begin
      if (open && k >= q.pos && n < 4'h8) begin
        ws[n[2:0]] = q.grp[k];
        n = n + 4'h1;
        if (!q.grp[k][`EPD_PBIT] || n == 4'h8) begin
          open = 1'b0;
          closed = 1'b1;
          npos = 4'(k + 1);
        end
      end
    end
    if (open) begin
      if (!q.ctrl[1]) begin
        closed = 1'b1;
        npos = 4'h8;
      end else begin
        npos = 4'h8;
      end
    end
    for (int s = 0; s < 8; s++) begin
      if (4'(s) < n) begin
        u = ws[s][`EPD_UNIT_LSB +: 3];
        if (busy[u]) begin
          stall = 1'b1;
        end
        if (used[u]) begin
          conf = 1'b1;
        end
        used[u] = 1'b1;
      end
    end
    for (int x = 0; x < 8; x++) begin
      if (q.uact[x] && q.ucnt[x] != 4'hf) begin
        d.ucnt[x] = q.ucnt[x] + 4'h1;
      end else begin
        d.uact[x] = 1'b0;
      end
    end
    if (q.have && q.ctrl[0] && !(closed && stall)) begin
      if (closed) begin
        d.iss = 1'b1;
        d.conf = conf;
        d.pcnt = 4'h0;
        for (int s = 0; s < 8; s++) begin
          d.imask[s] = 4'(s) < n;
          d.slot[s] = decode(ws[s]);
          if (4'(s) < n) begin
            u = ws[s][`EPD_UNIT_LSB +: 3];
            d.uact[u] = 1'b1;
            d.ucnt[u] = 4'h0;
            d.utm[u] = timing(ws[s][`EPD_CLS_LSB +: 4]);
          end
        end
      end else begin
        d.pkt = ws;
        d.pcnt = n;
      end
      d.pos = npos;
      d.have = npos != 4'h8;
    end
    if (!q.have && group_valid) begin
      d.grp = group_data;
      d.have = 1'b1;
      d.pos = 4'h0;
      d.faddr = q.faddr + `EPD_GROUP_BYTES;
    end
    d.sps = sp_operand[31];
    d.spc = fpcls(sp_operand[30:23] == 8'h00,
      sp_operand[30:23] == `EPD_SP_EMAX, sp_operand[22:0] == 23'h0,
      sp_operand[22]);
    d.spe = (sp_operand[30:23] == 8'h00) ? `EPD_SP_DEN_EXP :
      {2'h0, sp_operand[30:23]} - `EPD_SP_BIAS;
    d.spm = {sp_operand[30:23] != 8'h00, sp_operand[22:0]};
    d.dps = dp_odd_word[31];
    d.dpc = fpcls(dp_odd_word[30:20] == 11'h0,
      dp_odd_word[30:20] == `EPD_DP_EMAX,
      {dp_odd_word[19:0], dp_even_word} == 52'h0,
      dp_odd_word[19]);
    d.dpe = (dp_odd_word[30:20] == 11'h0) ? `EPD_DP_DEN_EXP :
      {1'b0, dp_odd_word[30:20]} - `EPD_DP_BIAS;
    d.dpm = {dp_odd_word[30:20] != 11'h0, dp_odd_word[19:0],
      dp_even_word};
    // Address and data may come in either order; each is held alone.
    if (s_axi_awvalid && !q.awh && !q.bv) begin
      d.awh = 1'b1;
      d.awa = s_axi_awaddr;
    end
    if (s_axi_wvalid && !q.wh && !q.bv) begin
      d.wh = 1'b1;
      d.wd = s_axi_wdata;
      wr_ok = s_axi_wstrb[0];
    end
    if (q.awh && q.wh && !q.bv) begin
      d.awh = 1'b0;
      d.wh = 1'b0;
      d.bv = 1'b1;
      if (q.awa[7:2] == `EPD_CTRL_OFS >> 2) begin
        d.br = 2'h0;
        d.ctrl = q.wd[1:0];
      end else if (q.awa[7:2] == `EPD_STAT_OFS >> 2) begin
        d.br = 2'h0;
      end else begin
        d.br = 2'h2;
      end
    end else if (q.bv && s_axi_bready) begin
      d.bv = 1'b0;
    end
    if (s_axi_arvalid && !q.rv) begin
      ra = s_axi_araddr;
      d.rv = 1'b1;
      d.rr = 2'h0;
      if (ra[7:2] == `EPD_CTRL_OFS >> 2) begin
        d.rd = {30'h0, q.ctrl};
      end else if (ra[7:2] == `EPD_STAT_OFS >> 2) begin
        d.rd = {16'h0, busy, q.pcnt, q.have, q.pos[2:0]};
      end else begin
        d.rd = 32'h0;
        d.rr = 2'h2;
      end
    end else if (q.rv && s_axi_rready) begin
      d.rv = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.faddr <= {START_ADDR[31:5], 5'h00};
      q.ctrl <= `EPD_CTRL_RST;
    end else begin
      q <= d;
    end
  end

  generate
    for (gu = 0; gu < 8; gu++) begin : g_out
      epd_pkg::epd_slot_t sl;
      assign sl = q.slot[gu];
      assign issue_word[gu] = sl.word;
      assign issue_dst_b[gu] = sl.dst_b;
      assign issue_src2_b[gu] = sl.src2_b;
      assign issue_ldst_two[gu] = sl.ldst_two;
      assign issue_load[gu] = sl.load;
    end
  endgenerate

  assign fetch_req = !q.have;
  assign group_ready = !q.have;
  assign fetch_addr = q.faddr;
  assign issue_valid = q.iss;
  assign issue_mask = q.imask;
  assign issue_unit_conflict = q.conf;
  assign unit_busy = busy;
  assign sp_class = q.spc;
  assign sp_sign = q.sps;
  assign sp_exponent = q.spe;
  assign sp_mantissa = q.spm;
  assign dp_class = q.dpc;
  assign dp_sign = q.dps;
  assign dp_exponent = q.dpe;
  assign dp_mantissa = q.dpm;
  assign default_quiet_nan_sp = `EPD_SP_NAN;
  assign default_quiet_nan_dp = `EPD_DP_NAN;
  assign s_axi_awready = !q.awh && !q.bv;
  assign s_axi_wready = !q.wh && !q.bv;
  assign s_axi_bvalid = q.bv;
  assign s_axi_bresp = q.br;
  assign s_axi_arready = !q.rv;
  assign s_axi_rvalid = q.rv;
  assign s_axi_rdata = q.rd;
  assign s_axi_rresp = q.rr;
endmodule : epd_dispatch

//--- epd_dispatch_monitor.sv
// Checker for the dispatcher: fetch alignment, packet shape, decode
// and word order. Bound to every epd_dispatch instance.
module epd_dispatch_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic fetch_req,
  input wire logic [31:0] fetch_addr,
  input wire logic issue_valid,
  input wire logic [7:0] issue_mask,
  input wire logic [7:0][31:0] issue_word,
  input wire logic [7:0] issue_dst_b,
  input wire logic [7:0] issue_src2_b,
  input wire logic [7:0] issue_ldst_two,
  input wire logic [7:0] issue_load,
  input wire logic [7:0] unit_read,
  input wire logic [7:0] unit_read_hi,
  input wire logic [7:0] unit_write_lo,
  input wire logic [7:0] unit_write_hi,
  input wire logic [31:0] sp_operand,
  input wire logic [2:0] sp_class,
  input wire logic [9:0] sp_exponent,
  input wire logic [31:0] default_quiet_nan_sp,
  input wire logic [63:0] default_quiet_nan_dp
);
  logic [7:0] side_x, cross_x, sel_x, dir_x;
  always_comb begin
    for (int k = 0; k < 8; k++) begin
      side_x[k] = issue_word[k][1];
      cross_x[k] = issue_word[k][1] ^ issue_word[k][12];
      sel_x[k] = issue_word[k][7];
      dir_x[k] = issue_word[k][6];
    end
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_group_aligned: assert property (
    fetch_req |-> fetch_addr[4:0] == 5'h00) else $error("unaligned fetch");
  a_mask_packed: assert property (
    issue_valid |-> issue_mask != 8'h00 &&
    (issue_mask & (issue_mask + 8'h01)) == 8'h00) else $error("bad mask");
  a_file_decode: assert property (
    issue_valid |-> ((issue_dst_b ^ side_x) & issue_mask) == 8'h00 &&
    ((issue_src2_b ^ cross_x) & issue_mask) == 8'h00) else $error("bad file");
  a_mem_decode: assert property (
    issue_valid |-> ((issue_ldst_two ^ sel_x) & issue_mask) == 8'h00 &&
    ((issue_load ^ dir_x) & issue_mask) == 8'h00) else $error("bad mem bits");
  a_hi_after_lo: assert property (
    unit_write_hi != 8'h00 |->
    (unit_write_hi & ~$past(unit_write_lo)) == 8'h00) else $error("hi first");
  a_read_order: assert property (
    unit_read_hi != 8'h00 |->
    (unit_read_hi & ~$past(unit_read)) == 8'h00) else $error("read order");
  a_sp_denorm: assert property (
    sp_operand[30:23] == 8'h00 && sp_operand[22:0] != 23'h0 |=>
    sp_class == 3'h2 && sp_exponent == 10'h382) else $error("denormal");
  a_nan_const: assert property (
    default_quiet_nan_sp == 32'h7fff_ffff &&
    default_quiet_nan_dp == 64'h7fff_ffff_ffff_ffff) else $error("nan");
endmodule : epd_dispatch_monitor
bind epd_dispatch epd_dispatch_monitor i_epd_dispatch_monitor (.*);

//--- epd_fetch_model.sv
// Fetch-side model: answers aligned group requests from a program store.
// Assumes the bench fills prog and raises avail; stall slows answers.
module epd_fetch_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic fetch_req,
  input wire logic [31:0] fetch_addr,
  input wire logic group_ready,
  output logic group_valid,
  output logic [255:0] group_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0][31:0] prog [0:7];
  int avail = 0;
  int stall = 0;
  int wait_n;
  // Idle data toggles each cycle so a stale group never looks valid.
  always @(posedge aclk) begin
    if (!aresetn) begin
      group_valid <= 1'b0;
      group_data <= {8{32'h5a5a_a5a5}};
      wait_n <= 0;
    end else if (group_valid) begin
      if (group_ready) begin
        group_valid <= 1'b0;
        group_data <= ~group_data;
      end
    end else if (fetch_req && int'(fetch_addr[9:5]) < avail) begin
      if (wait_n < stall) begin
        wait_n <= wait_n + 1;
        group_data <= ~group_data;
      end else begin
        wait_n <= 0;
        group_valid <= 1'b1;
        group_data <= prog[fetch_addr[7:5]];
      end
    end else begin
      group_data <= ~group_data;
    end
  end
endmodule : epd_fetch_model

//--- epd_dispatch_tb.sv
// Bench for epd_dispatch: packet splitting, unit timing, classifier.
// Assumes epd_fetch_model feeds groups and the monitor is bound.
module epd_dispatch_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, fetch_req, group_valid, group_ready, issue_valid;
  logic issue_unit_conflict, sp_sign, dp_sign, cls_new, cls_chk;
  logic [31:0] fetch_addr, sp_operand, dp_even_word, dp_odd_word, s, lw;
  logic [31:0] s_axi_wdata, s_axi_rdata, default_quiet_nan_sp;
  logic [255:0] group_data;
  logic [7:0] issue_mask, issue_dst_b, issue_src2_b, issue_ldst_two;
  logic [7:0] issue_load, unit_busy, unit_read, unit_read_hi;
  logic [7:0] unit_write_lo, unit_write_hi, unit_late_write, unit_readable;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [7:0][31:0] issue_word;
  logic [2:0] sp_class, dp_class;
  logic [9:0] sp_exponent;
  logic [23:0] sp_mantissa;
  logic [11:0] dp_exponent;
  logic [52:0] dp_mantissa;
  logic [63:0] default_quiet_nan_dp, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  int mismatches, tests_run, seed;
  logic [39:0] pq[$];
  logic [39:0] n;
  logic [106:0] cq[$];
  logic [106:0] c, ce;
  localparam logic [31:0] SPV [0:7] = '{32'h0, 32'h8000_0000, 32'h3f80_0000,
    32'h007f_ffff, 32'h7f80_0000, 32'hff80_0000, 32'h7fc0_0000, 32'h7f80_0001};
  localparam logic [63:0] DPV [0:7] = '{64'h0, 64'h8000_0000_0000_0001,
    64'h3ff0_0000_0000_0000, 64'h7ff0_0000_0000_0000, 64'hfff8_0000_0000_0000,
    64'h7ff0_0000_0000_0001, 64'h7fef_ffff_ffff_ffff, 64'h000f_ffff_ffff_ffff};
  epd_dispatch i_epd_dispatch (.*);
  epd_fetch_model i_epd_fetch_model (.*);
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  initial begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    tally_and_finish;
  end
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string nm, input logic [63:0] sn, ex);
    tests_run++;
    if (sn !== ex) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, sn);
    end
  endtask : chk
  function automatic logic [2:0] fcls(input logic ez, em, fz, fm);
    if (ez) return fz ? 3'h0 : 3'h2;
    if (em) return fz ? 3'h3 : (fm ? 3'h4 : 3'h5);
    return 3'h1;
  endfunction : fcls
  task automatic put(input int g, k, input int u, cl, input logic p);
    lw = $random(seed);
    lw[0] = p;
    lw[4:2] = 3'(u);
    lw[11:8] = 4'(cl);
    i_epd_fetch_model.prog[g][k] = lw;
  endtask : put
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (s_axi_awready) aw = 1'b1;
      if (s_axi_wready) w = 1'b1;
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk("bresp", s_axi_bresp, {a[4], 1'b0});
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] v);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk("rdata", s_axi_rdata, v);
    chk("rresp", s_axi_rresp, {a[4], 1'b0});
  endtask : axi_rd
  task automatic tchk(input logic [31:0] w);
    int u;
    u = w[4:2];
    if (w[11:8] == 4'h7) begin
      chk("busy", unit_busy[u], 1'b1);
      @(negedge aclk);
      chk("free", unit_busy[u], 1'b0);
      chk("read_hi", unit_read_hi[u], 1'b1);
      repeat (4) @(negedge aclk);
      chk("write_lo", unit_write_lo[u], 1'b1);
      @(negedge aclk);
      chk("write_hi", unit_write_hi[u], 1'b1);
      @(negedge aclk);
      chk("readable", unit_readable[u], 1'b1);
    end else if (w[11:8] == 4'h5) begin
      repeat (4) @(negedge aclk);
      chk("late_write", unit_late_write[u], 1'b1);
      @(negedge aclk);
      chk("ld_readable", unit_readable[u], 1'b1);
    end
  endtask : tchk
  always @(posedge aclk) cls_chk <= cls_new;
  always @(negedge aclk) begin
    if (issue_valid === 1'b1) begin
      n = (pq.size() > 0) ? pq.pop_front() : '1;
      chk("issue_mask", issue_mask, n[39:32]);
      chk("issue_word", issue_word[0], n[31:0]);
      chk("conflict", issue_unit_conflict, 1'b0);
      fork
        tchk(issue_word[0]);
      join_none
    end
    if (cls_chk === 1'b1) begin
      c = cq.pop_front();
      chk("sp_class", sp_class, c[53:51]);
      chk("sp_sign", sp_sign, c[50]);
      chk("dp_class", dp_class, c[15:13]);
      chk("dp_sign", dp_sign, c[12]);
      if (c[53:51] < 3'h3) chk("sp_exp", sp_exponent, c[49:40]);
      if (c[53:51] < 3'h3) chk("sp_man", sp_mantissa, c[39:16]);
      if (c[15:13] < 3'h3) chk("dp_exp", dp_exponent, c[11:0]);
      if (c[15:13] < 3'h3) chk("dp_man", dp_mantissa, c[106:54]);
    end
  end
  initial begin
    seed = 4931;
    {aresetn, cls_new, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, sp_operand, dp_even_word, dp_odd_word} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    put(0, 0, 0, 7, 1'b0);
    pq.push_back({8'h01, lw});
    put(0, 1, 1, 5, 1'b0);
    pq.push_back({8'h01, lw});
    for (int k = 2; k < 8; k++) begin
      put(0, k, k, 0, k != 4 && k != 7);
      if (k == 2 || k == 5) s = lw;
      if (k == 4 || k == 7) pq.push_back({8'h07, s});
    end
    for (int k = 0; k < 8; k++) put(1, k, k, 0, 1'b1);
    pq.push_back({8'hff, i_epd_fetch_model.prog[1][0]});
    for (int k = 0; k < 8; k++) begin
      put(2, k, k, 0, k > 5);
      if (k < 6) pq.push_back({8'h01, lw});
    end
    put(3, 0, 2, 0, 1'b0);
    pq.push_back({8'h07, i_epd_fetch_model.prog[2][6]});
    for (int k = 1; k < 8; k++) begin
      put(3, k, k, 0, 1'b0);
      pq.push_back({8'h01, lw});
    end
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axi_rd(8'h00, 32'h1);
    axi_rd(8'h10, 32'h0);
    axi_wr(8'h10, 32'hffff_ffff);
    i_epd_fetch_model.avail <= 2;
    // Slow fetch so the long units finish before group one reuses them.
    i_epd_fetch_model.stall <= 3;
    while (pq.size() > 14) @(posedge aclk);
    for (int i = 0; i < 9; i++) begin
      @(posedge aclk);
      s = (i < 8) ? SPV[i] : $random(seed) & 32'hbfff_ffff | 32'h0080_0000;
      d = (i < 8) ? DPV[i] : {$random(seed), $random(seed)};
      if (i == 8) d[62:52] = {2'h0, d[60:53], 1'b1};
      ce[53:51] = fcls(s[30:23] == 8'h0, &s[30:23], s[22:0] == 23'h0, s[22]);
      ce[50] = s[31];
      ce[49:40] = (s[30:23] == 8'h0) ? 10'h382 : {2'h0, s[30:23]} - 10'h07f;
      ce[39:16] = {s[30:23] != 8'h0, s[22:0]};
      ce[15:13] = fcls(d[62:52] == 11'h0, &d[62:52], d[51:0] == 52'h0, d[51]);
      ce[12] = d[63];
      ce[11:0] = (d[62:52] == 11'h0) ? 12'hc02 : {1'b0, d[62:52]} - 12'h3ff;
      ce[106:54] = {d[62:52] != 11'h0, d[51:0]};
      cq.push_back(ce);
      sp_operand <= s;
      {dp_odd_word, dp_even_word} <= d;
      cls_new <= 1'b1;
    end
    @(posedge aclk);
    cls_new <= 1'b0;
    axi_wr(8'h00, 32'h3);
    axi_rd(8'h00, 32'h3);
    axi_rd(8'h04, 32'h0);
    i_epd_fetch_model.stall <= 2;
    i_epd_fetch_model.avail <= 4;
    while (pq.size() > 0) @(posedge aclk);
    repeat (10) @(posedge aclk);
    tally_and_finish;
  end
endmodule : epd_dispatch_tb
